//--- src/ebp_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Upper port carries high address and data lines
// - Lower port carries low address, plus low data in wide modes, else plain pins
// - Direction one drives pin, zero floats it
// - Read returns pin if input, latch if output
// - Expanded or peripheral: ports leave map, go external
// - Direction registers reset to all zeros
// - Reserved locations read zero, writes ignored
// - Peripheral mode removes reserved locations from map
// - Control port 7:2 are I/O, 1:0 inputs
// - Assignment picks function, direction only for general use
// - One bit enables pulls; interrupt pins pull up
// - Control latch leaves map in peripheral or emulated
// - Interrupt pins never outputs, always readable
// - Control function overrides the direction bit
module ebp_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ebp_pkg::ADDR_W-1:0] paddr,
  input wire logic [ebp_pkg::DATA_W-1:0] pwdata,
  output logic [ebp_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Accesses echoed to the external bus
  output ebp_pkg::ebp_xreq_t xbus_req,
  input wire logic xbus_ack,
  input wire logic [7:0] xbus_rdata,
  // External bus engine
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_data_phase,
  input wire logic bus_drive_data,
  output logic [15:0] bus_pin_data,
  // Control functions on the control port
  input wire logic [7:0] ctl_fn_out,
  input wire logic [7:0] ctl_fn_oe,
  // Upper port pins
  input wire logic [7:0] upper_pin_in,
  output logic [7:0] upper_pin_out,
  output logic [7:0] upper_pin_oe,
  // Lower port pins
  input wire logic [7:0] lower_pin_in,
  output logic [7:0] lower_pin_out,
  output logic [7:0] lower_pin_oe,
  // Control port pins
  input wire logic [7:0] ctl_pin_in,
  output logic [7:0] ctl_pin_out,
  output logic [7:0] ctl_pin_oe,
  output logic [7:0] ctl_pull_en
);
  import ebp_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] upper_port_latch_r;
  logic [7:0] lower_port_latch_r;
  logic [7:0] upper_port_direction_r;
  logic [7:0] lower_port_direction_r;
  logic [7:0] control_port_latch_r;
  logic [7:0] control_port_direction_r;
  logic [7:0] control_port_assignment_r;
  ebp_mode_t mode_r;
  logic emulate_control_port_map_r;
  logic pull_en_r;
  ebp_state_t state_r;
  ebp_state_t state_nxt;
  logic [IDX_W-1:0] acc_idx_r;
  logic acc_int_r;
  logic [DATA_W-1:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  ebp_xreq_t xreq_r;
  logic [15:0] bus_pin_data_r;
  logic [7:0] ctl_pull_en_r;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] upper_pin_s;
  logic [7:0] lower_pin_s;
  logic [7:0] ctl_pin_s;

  ebp_sync #(.W(8)) u_sync_upper (
    .pclk(pclk),
    .presetn(presetn),
    .raw(upper_pin_in),
    .q(upper_pin_s)
  );

  ebp_sync #(.W(8)) u_sync_lower (
    .pclk(pclk),
    .presetn(presetn),
    .raw(lower_pin_in),
    .q(lower_pin_s)
  );

  ebp_sync #(.W(8)) u_sync_ctl (
    .pclk(pclk),
    .presetn(presetn),
    .raw(ctl_pin_in),
    .q(ctl_pin_s)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire logic is_narrow = (mode_r == MD_NORMAL_NARROW) | (mode_r == MD_EMU_NARROW);
  wire logic is_wide = (mode_r == MD_NORMAL_WIDE) | (mode_r == MD_EMU_WIDE) |
                       (mode_r == MD_SPECIAL_TEST);
  wire logic is_expanded = is_narrow | is_wide;
  wire logic is_periph = (mode_r == MD_PERIPHERAL);
  wire logic ab_gone = is_expanded | is_periph;
  wire logic eme_gone = is_expanded & emulate_control_port_map_r;

  // ----------------------------------------------------------------
  // Bus function on the address/data ports
  // ----------------------------------------------------------------
  // Address goes out first, data follows in the data phase
  wire logic [7:0] upper_bus_byte = !bus_data_phase ? bus_addr[15:8] :
                                    is_wide ? bus_wdata[15:8] : bus_wdata[7:0];
  wire logic [7:0] lower_bus_byte = (is_wide & bus_data_phase) ? bus_wdata[7:0] :
                                    bus_addr[7:0];
  wire logic muxed_oe = !bus_data_phase | bus_drive_data;
  // In narrow mode the lower port never turns round: address only
  wire logic lower_bus_oe = is_narrow ? 1'b1 : muxed_oe;
  // In peripheral mode an outside master drives these pins
  wire logic [7:0] upper_alt_oe = is_expanded & muxed_oe ? ALL_ONES : RST_BYTE;
  wire logic [7:0] lower_alt_oe = is_expanded & lower_bus_oe ? ALL_ONES : RST_BYTE;
  wire logic [7:0] ab_alt_sel = ab_gone ? ALL_ONES : RST_BYTE;

  wire ebp_alt_t upper_alt = '{sel: ab_alt_sel, out: upper_bus_byte, oe: upper_alt_oe};
  wire ebp_alt_t lower_alt = '{sel: ab_alt_sel, out: lower_bus_byte, oe: lower_alt_oe};
  // Pins 1:0 have no assignment bit and no output path
  wire ebp_alt_t ctl_alt = '{
    sel: control_port_assignment_r & PE_IO_MASK,
    out: ctl_fn_out,
    oe: ctl_fn_oe
  };

  // ----------------------------------------------------------------
  // Port slices
  // ----------------------------------------------------------------
  logic [7:0] upper_rd;
  logic [7:0] lower_rd;
  logic [7:0] ctl_rd;
  logic [7:0] ctl_oe_q;

  ebp_port u_port_upper (
    .pclk(pclk),
    .presetn(presetn),
    .latch(upper_port_latch_r),
    .dir(upper_port_direction_r),
    .io_mask(ALL_ONES),
    .rd_val(upper_rd),
    .alt(upper_alt),
    .pin_in(upper_pin_s),
    .pin_out_r(upper_pin_out),
    .pin_oe_r(upper_pin_oe)
  );

  ebp_port u_port_lower (
    .pclk(pclk),
    .presetn(presetn),
    .latch(lower_port_latch_r),
    .dir(lower_port_direction_r),
    .io_mask(ALL_ONES),
    .rd_val(lower_rd),
    .alt(lower_alt),
    .pin_in(lower_pin_s),
    .pin_out_r(lower_pin_out),
    .pin_oe_r(lower_pin_oe)
  );

  // The mask keeps pins 1:0 inputs whatever software or the alternate side asks
  ebp_port u_port_ctl (
    .pclk(pclk),
    .presetn(presetn),
    .latch(control_port_latch_r),
    .dir(control_port_direction_r),
    .io_mask(PE_IO_MASK),
    .rd_val(ctl_rd),
    .alt(ctl_alt),
    .pin_in(ctl_pin_s),
    .pin_out_r(ctl_pin_out),
    .pin_oe_r(ctl_oe_q)
  );

  assign ctl_pin_oe = ctl_oe_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic setup = psel & !penable;
  wire logic [IDX_W-1:0] idx = paddr[IDX_LSB +: IDX_W];
  wire logic idx_mapped = (idx <= IDX_LAST);
  wire logic idx_is_ab = (idx <= IDX_LOWER_DIR);
  wire logic idx_is_rsvd = ((idx >= IDX_RSVD_FIRST) & (idx <= IDX_RSVD_LAST)) |
                           (idx > IDX_PULL);
  wire logic in_map = idx_is_ab ? !ab_gone :
                      idx_is_rsvd ? !is_periph :
                      (idx == IDX_CTL_LATCH) ? !(is_periph | eme_gone) :
                      (idx == IDX_CTL_DIR) ? !(ab_gone | eme_gone) :
                      (idx == IDX_CTL_ASSIGN) ? !ab_gone : 1'b1;
  wire logic go_ext = idx_mapped & !in_map;

  // ----------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------
  wire logic [7:0] mode_rd = {emulate_control_port_map_r, 4'h0, mode_r};
  wire logic [7:0] pull_rd = {3'h0, pull_en_r, 4'h0};
  wire logic [7:0] rd_byte = (idx == IDX_UPPER_LATCH) ? upper_rd :
                             (idx == IDX_LOWER_LATCH) ? lower_rd :
                             (idx == IDX_UPPER_DIR) ? upper_port_direction_r :
                             (idx == IDX_LOWER_DIR) ? lower_port_direction_r :
                             (idx == IDX_CTL_LATCH) ? ctl_rd :
                             (idx == IDX_CTL_DIR) ? control_port_direction_r :
                             (idx == IDX_CTL_ASSIGN) ? control_port_assignment_r :
                             (idx == IDX_MODE) ? mode_rd :
                             (idx == IDX_PULL) ? pull_rd : RST_BYTE;

  // ----------------------------------------------------------------
  // Bus slave sequencing
  // ----------------------------------------------------------------
  // Writes land only at the handshake edge, so software that reads a port
  // right after changing its direction already reads through the new direction on that access
  wire logic handshake = (state_r == ST_DONE) & psel & penable;
  wire logic wr_fire = handshake & pwrite & acc_int_r;
  wire logic [7:0] wbyte = pwdata[BYTE_W-1:0];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (setup) begin
          state_nxt = go_ext ? ST_EXT : ST_DONE;
        end
      end
      ST_EXT: begin
        if (xbus_ack) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        if (handshake) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      acc_idx_r <= '0;
      acc_int_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && setup) begin
        acc_idx_r <= idx;
        acc_int_r <= idx_mapped & in_map;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (state_r == ST_IDLE && setup && !go_ext) begin
      prdata_r <= {RD_PAD, rd_byte};
      pready_r <= 1'b1;
      pslverr_r <= !idx_mapped;
    end else if (state_r == ST_EXT && xbus_ack) begin
      prdata_r <= {RD_PAD, xbus_rdata};
      pready_r <= 1'b1;
    end else if (handshake) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // Out-of-map accesses are echoed on the external bus until it acknowledges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xreq_r <= '0;
    end else if (state_r == ST_IDLE && setup && go_ext) begin
      xreq_r <= '{valid: 1'b1, write: pwrite, addr: paddr, wdata: wbyte};
    end else if (xbus_ack) begin
      xreq_r.valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  wire logic wr_upper_latch = wr_fire & (acc_idx_r == IDX_UPPER_LATCH);
  wire logic wr_lower_latch = wr_fire & (acc_idx_r == IDX_LOWER_LATCH);
  wire logic wr_upper_dir = wr_fire & (acc_idx_r == IDX_UPPER_DIR);
  wire logic wr_lower_dir = wr_fire & (acc_idx_r == IDX_LOWER_DIR);
  wire logic wr_ctl_latch = wr_fire & (acc_idx_r == IDX_CTL_LATCH);
  wire logic wr_ctl_dir = wr_fire & (acc_idx_r == IDX_CTL_DIR);
  wire logic wr_ctl_assign = wr_fire & (acc_idx_r == IDX_CTL_ASSIGN);
  wire logic wr_mode = wr_fire & (acc_idx_r == IDX_MODE);
  wire logic wr_pull = wr_fire & (acc_idx_r == IDX_PULL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_port_latch_r <= RST_BYTE;
      lower_port_latch_r <= RST_BYTE;
      upper_port_direction_r <= RST_BYTE;
      lower_port_direction_r <= RST_BYTE;
    end else begin
      if (wr_upper_latch) upper_port_latch_r <= wbyte;
      if (wr_lower_latch) lower_port_latch_r <= wbyte;
      if (wr_upper_dir) upper_port_direction_r <= wbyte;
      if (wr_lower_dir) lower_port_direction_r <= wbyte;
    end
  end

  // Direction and assignment bits 1:0 stay zero: those pins are inputs only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_port_latch_r <= RST_BYTE;
      control_port_direction_r <= RST_BYTE;
      control_port_assignment_r <= RST_BYTE;
    end else begin
      if (wr_ctl_latch) control_port_latch_r <= wbyte;
      if (wr_ctl_dir) control_port_direction_r <= wbyte & PE_IO_MASK;
      if (wr_ctl_assign) control_port_assignment_r <= wbyte & PE_IO_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= RST_MODE;
      emulate_control_port_map_r <= 1'b0;
      pull_en_r <= 1'b0;
    end else begin
      if (wr_mode) mode_r <= ebp_mode_t'(wbyte[MODE_LSB +: MODE_W]);
      if (wr_mode) emulate_control_port_map_r <= wbyte[EME_BIT];
      if (wr_pull) pull_en_r <= wbyte[PULL_E_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Pull control and bus-side pin capture
  // ----------------------------------------------------------------
  // Pull sense on 1:0 is always up; other pins' sense is fixed by the pad ring
  wire logic [7:0] pull_nxt = pull_en_r ? (PE_PULL_MASK & ~ctl_oe_q) : RST_BYTE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_pull_en_r <= RST_BYTE;
      bus_pin_data_r <= '0;
    end else begin
      ctl_pull_en_r <= pull_nxt;
      bus_pin_data_r <= {upper_pin_s, lower_pin_s};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign xbus_req = xreq_r;
  assign bus_pin_data = bus_pin_data_r;
  assign ctl_pull_en = ctl_pull_en_r;

endmodule : ebp_top

//--- src/ebp_pkg.sv
package ebp_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;
  localparam int IDX_LSB = 2;
  localparam int BYTE_W = 8;
  localparam logic [DATA_W-BYTE_W-1:0] RD_PAD = 24'h000000;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_UPPER_LATCH = 6'h00;
  localparam logic [IDX_W-1:0] IDX_LOWER_LATCH = 6'h01;
  localparam logic [IDX_W-1:0] IDX_UPPER_DIR = 6'h02;
  localparam logic [IDX_W-1:0] IDX_LOWER_DIR = 6'h03;
  localparam logic [IDX_W-1:0] IDX_RSVD_FIRST = 6'h04;
  localparam logic [IDX_W-1:0] IDX_RSVD_LAST = 6'h07;
  localparam logic [IDX_W-1:0] IDX_CTL_LATCH = 6'h08;
  localparam logic [IDX_W-1:0] IDX_CTL_DIR = 6'h09;
  localparam logic [IDX_W-1:0] IDX_CTL_ASSIGN = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_MODE = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_PULL = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_LAST = 6'h0F;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int EME_BIT = 7;
  localparam int PULL_E_BIT = 4;
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
  localparam logic [BYTE_W-1:0] ALL_ONES = 8'hFF;
  localparam logic [BYTE_W-1:0] PE_IO_MASK = 8'hFC;
  localparam logic [BYTE_W-1:0] PE_PULL_MASK = 8'h9F;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MD_SPECIAL_SINGLE = 3'h0,
    MD_EMU_NARROW = 3'h1,
    MD_SPECIAL_TEST = 3'h2,
    MD_EMU_WIDE = 3'h3,
    MD_NORMAL_SINGLE = 3'h4,
    MD_NORMAL_NARROW = 3'h5,
    MD_PERIPHERAL = 3'h6,
    MD_NORMAL_WIDE = 3'h7
  } ebp_mode_t;

  localparam ebp_mode_t RST_MODE = MD_NORMAL_SINGLE;

  // ----------------------------------------------------------------
  // Bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXT = 3'b010,
    ST_DONE = 3'b100
  } ebp_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [BYTE_W-1:0] sel;
    logic [BYTE_W-1:0] out;
    logic [BYTE_W-1:0] oe;
  } ebp_alt_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } ebp_xreq_t;

endpackage : ebp_pkg

//--- src/ebp_sync.sv
`timescale 1ns/1ps
module ebp_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous pins in, settled value out
  input wire logic [W-1:0] raw,
  output logic [W-1:0] q
);
  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;
  logic [W-1:0] q_r;
  wire logic [W-1:0] agree = ~(ff2_r ^ ff3_r);

  // A bit changes only once two late stages agree, filtering one-cycle glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff1_r <= '0;
      ff2_r <= '0;
      ff3_r <= '0;
      q_r <= '0;
    end else begin
      ff1_r <= raw;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      q_r <= (agree & ff3_r) | (~agree & q_r);
    end
  end

  assign q = q_r;
endmodule : ebp_sync

//--- src/ebp_port.sv
`timescale 1ns/1ps
module ebp_port (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Software view
  input wire logic [7:0] latch,
  input wire logic [7:0] dir,
  input wire logic [7:0] io_mask,
  output logic [7:0] rd_val,
  // Alternate function
  input wire ebp_pkg::ebp_alt_t alt,
  // Pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out_r,
  output logic [7:0] pin_oe_r
);
  import ebp_pkg::*;

  wire logic [7:0] gpio_oe = dir & io_mask;
  wire logic [7:0] oe_nxt = (alt.sel & alt.oe & io_mask) | (~alt.sel & gpio_oe);
  wire logic [7:0] out_nxt = (alt.sel & alt.out) | (~alt.sel & latch);

  // Output bits read the latch, input bits read the settled pin
  assign rd_val = (dir & latch) | (~dir & pin_in);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_r <= RST_BYTE;
      pin_oe_r <= RST_BYTE;
    end else begin
      pin_out_r <= out_nxt;
      pin_oe_r <= oe_nxt;
    end
  end
endmodule : ebp_port

//--- verification/ebp_top_asserts.sv
`timescale 1ns/1ps
module ebp_top_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ebp_pkg::ADDR_W-1:0] paddr,
  input wire logic [ebp_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Echo
  input wire ebp_pkg::ebp_xreq_t xbus_req,
  input wire logic xbus_ack,
  // Pins
  input wire logic [7:0] upper_pin_oe,
  input wire logic [7:0] lower_pin_oe,
  input wire logic [7:0] ctl_pin_oe,
  input wire logic [7:0] ctl_pull_en
);
  import ebp_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [5:0] idx = paddr[7:2];
  wire rsvd = idx inside {[4:7], [13:15]};

  a_int_pins_in: assert property (ctl_pin_oe[1:0] == 2'h0)
    else $error("interrupt pin driven");
  a_dir_reset: assert property ($rose(presetn) |-> (upper_pin_oe | lower_pin_oe) == 8'h00)
    else $error("pins driven after reset");
  a_rsvd_zero: assert property (pready && !pwrite && rsvd && !$past(xbus_req.valid)
    |-> prdata == 32'h0) else $error("reserved read not zero");
  a_rd_pad: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_unmapped_err: assert property (psel && !penable && !pready && idx > 15
    |=> pready && pslverr && prdata == 32'h0) else $error("unmapped access");
  a_mapped_ok: assert property (pready && idx <= 15 |-> !pslverr)
    else $error("error on mapped access");
  a_echo_hold: assert property (xbus_req.valid && !xbus_ack |=> xbus_req.valid && $stable(xbus_req))
    else $error("echo dropped early");
  a_echo_done: assert property (xbus_req.valid && xbus_ack |=> pready && !xbus_req.valid)
    else $error("echo not completed");
  a_echo_addr: assert property ($rose(xbus_req.valid)
    |-> xbus_req.addr == paddr && xbus_req.write == pwrite) else $error("echo request wrong");
  a_pull_mask: assert property ((ctl_pull_en & 8'h60) == 8'h00)
    else $error("pull on pin without pull");
endmodule : ebp_top_asserts

bind ebp_top ebp_top_asserts ebp_top_asserts_i (.*);

//--- verification/ebp_xbus_model.sv
`timescale 1ns/1ps
module ebp_xbus_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Echoed access
  input wire ebp_pkg::ebp_xreq_t xbus_req,
  output logic xbus_ack,
  output logic [7:0] xbus_rdata,
  // Answer delay in cycles
  input wire logic [3:0] delay
);
  import ebp_pkg::*;
  logic [7:0] mem_r [256];
  logic [3:0] wait_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xbus_ack <= 1'b0;
      xbus_rdata <= 8'h5A;
      wait_r <= 4'h0;
    end else if (xbus_ack) begin
      // Data are only valid in the answer cycle; afterwards they toggle
      xbus_ack <= 1'b0;
      xbus_rdata <= ~xbus_rdata;
      wait_r <= 4'h0;
    end else if (xbus_req.valid && wait_r >= delay) begin
      xbus_ack <= 1'b1;
      xbus_rdata <= mem_r[xbus_req.addr];
      if (xbus_req.write) begin
        mem_r[xbus_req.addr] <= xbus_req.wdata;
      end
    end else begin
      xbus_rdata <= ~xbus_rdata;
      wait_r <= wait_r + {3'h0, xbus_req.valid};
    end
  end
endmodule : ebp_xbus_model

//--- verification/ebp_top_test.sv
`timescale 1ns/1ps
module ebp_top_test;
  import ebp_pkg::*;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic bus_data_phase = '0, bus_drive_data = '0, xbus_ack, pready, pslverr, nw;
  logic [7:0] paddr = '0, upper_pin_in = '0, lower_pin_in = '0, ctl_pin_in = '0;
  logic [7:0] ctl_fn_out = '0, ctl_fn_oe = '0, xbus_rdata, upper_pin_out, upper_pin_oe;
  logic [7:0] lower_pin_out, lower_pin_oe, ctl_pin_out, ctl_pin_oe, ctl_pull_en;
  logic [7:0] v, lat, ph, dd[2];
  logic [15:0] bus_addr = '0, bus_wdata = '0, bus_pin_data;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] delay = '0;
  logic [8:0] e;
  logic [8:0] exp_q[$];
  logic [5:0] rs[7] = '{4, 5, 6, 7, 13, 14, 15};
  logic [5:0] ix[4] = '{0, 2, 4, 8};
  logic [2:0] md[6] = '{1, 2, 3, 5, 6, 7};
  int num_errors = 0;
  int num_checks = 0;

  always #25 pclk = ~pclk;

  ebp_xreq_t xbus_req;
  ebp_top ebp_top_i (.*);
  ebp_xbus_model ebp_xbus_model_i (.pclk(pclk), .presetn(presetn), .xbus_req(xbus_req),
    .xbus_ack(xbus_ack), .xbus_rdata(xbus_rdata), .delay(delay));

  task automatic chk(string n, logic [7:0] ex, logic [7:0] got);
    num_checks++;
    if (got !== ex) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, ex, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // One APB transfer; the expected answer is queued for the monitor
  task automatic apb(logic w, logic [5:0] i, logic [7:0] wd, logic [7:0] rd, logic er = 1'b0);
    int n;
    exp_q.push_back({er, rd});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'($urandom), wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle();
    repeat (3) @(negedge pclk);
  endtask : settle

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("pslverr", {7'h0, e[8]}, {7'h0, pslverr});
      if (!pwrite) chk("prdata", e[7:0], prdata[7:0]);
    end
  end

  initial begin
    void'($urandom(32));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    upper_pin_in <= 8'($urandom);
    lower_pin_in <= 8'($urandom);
    ctl_pin_in <= 8'($urandom);
    repeat (6) @(posedge pclk);
    settle();
    chk("pin_hi", upper_pin_in, bus_pin_data[15:8]);
    chk("pin_lo", lower_pin_in, bus_pin_data[7:0]);
    for (int p = 0; p < 2; p++) begin
      v = p ? lower_pin_in : upper_pin_in;
      apb(0, 6'(p + 2), 0, 8'h00);
      apb(0, 6'(p), 0, v);
      dd[p] = 8'($urandom);
      lat = 8'($urandom);
      apb(1, 6'(p), lat, 0);
      apb(1, 6'(p + 2), dd[p], 0);
      settle();
      chk("port_oe", dd[p], p ? lower_pin_oe : upper_pin_oe);
      chk("port_out", lat, p ? lower_pin_out : upper_pin_out);
      apb(0, 6'(p), 0, (lat & dd[p]) | (v & ~dd[p]));
    end
    foreach (rs[k]) begin
      apb(1, rs[k], 8'hFF, 0);
      apb(0, rs[k], 0, 8'h00);
    end
    apb(1, 6'h10, 8'hA5, 0, 1'b1);
    apb(0, 6'h3F, 0, 8'h00, 1'b1);
    apb(1, 9, 8'hFF, 0);
    lat = 8'($urandom);
    apb(1, 8, lat, 0);
    settle();
    chk("ctl_oe", 8'hFC, ctl_pin_oe);
    chk("ctl_out", lat & 8'hFC, ctl_pin_out & 8'hFC);
    apb(0, 9, 0, 8'hFC);
    apb(0, 8, 0, (lat & 8'hFC) | (ctl_pin_in & 8'h03));
    ctl_fn_oe <= 8'($urandom);
    ctl_fn_out <= 8'($urandom);
    apb(1, 10, 8'hFC, 0);
    settle();
    chk("fn_oe", ctl_fn_oe & 8'hFC, ctl_pin_oe);
    chk("fn_out", ctl_fn_out & 8'hFC, ctl_pin_out & 8'hFC);
    apb(1, 10, 0, 0);
    apb(1, 12, 8'h10, 0);
    apb(1, 9, 8'h80, 0);
    settle();
    chk("pull", 8'h1F, ctl_pull_en);
    foreach (md[k]) begin
      apb(1, 11, {5'h10, md[k]}, 0);
      apb(0, 11, 0, {5'h10, md[k]});
      delay <= 4'($urandom_range(0, 5));
      foreach (ix[j]) begin
        v = 8'($urandom);
        apb(1, ix[j], v, 0);
        apb(0, ix[j], 0, (ix[j] == 4 && md[k] != 6) ? 8'h00 : v);
      end
      bus_addr <= 16'($urandom);
      bus_wdata <= 16'($urandom);
      bus_data_phase <= 1'($urandom);
      bus_drive_data <= 1'b1;
      settle();
      nw = md[k] inside {1, 5};
      ph = md[k] == 6 ? 8'h00 : 8'hFF;
      chk("upper_oe", ph, upper_pin_oe);
      chk("lower_oe", ph, lower_pin_oe);
      if (md[k] != 6) begin
        chk("upper_out", bus_data_phase ? (nw ? bus_wdata[7:0] : bus_wdata[15:8]) :
          bus_addr[15:8], upper_pin_out);
        chk("lower_out", (bus_data_phase && !nw) ? bus_wdata[7:0] : bus_addr[7:0],
          lower_pin_out);
      end
    end
    apb(1, 11, 8'h00, 0);
    apb(0, 11, 0, 8'h00);
    apb(0, 2, 0, dd[0]);
    apb(0, 3, 0, dd[1]);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 3, 0, 8'h00);
    tally_and_finish();
  end
endmodule : ebp_top_test
